// *** usart_spi.sv ***
// SPI master/slave mode of the multi-mode serial controller
//
// Summary of operation
// - Mode code 0xE selects SPI master.
// - Mode code 0xF selects SPI slave.
// - Master drives data out, clock, select.
// - Slave takes data in, clock, select.
// - Slave always clocks from the clock pin.
// - Up to nine bits, no framing bits.
// - Length from field, nine-bit overrides; MSB first.
// - Bus modes map to polarity/phase; both ends match.
// - Wait-read holds master transmit until receive read; the slave still loads and sends.
// - Master select: one bit lead, trail, three gap.
// - Force holds select low; only release frees.
// - Transmit ready/empty flags low when disabled; writes unready dropped.
// - Slave underrun flags and holds output high.
// - Slave starts on low select level.
// - Completion loads receive; overrun when still full.
// - Receiver timeout never fires in SPI.
`timescale 1ns/1ps
module usart_spi (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] mode_in,
  input wire logic clock_output_enable_in,
  input wire logic [15:0] baud_divider_in,
  input wire logic [1:0] char_length_field_in,
  input wire logic nine_bit_in,
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic wait_read_before_send_in,
  input wire logic tx_enable_in,
  input wire logic rx_enable_in,
  input wire logic tx_reset_in,
  input wire logic rx_reset_in,
  input wire logic select_force_bit_in,
  input wire logic select_release_bit_in,
  input wire logic status_reset_bit_in,
  input wire logic tx_write_in,
  input wire logic [8:0] tx_data_in,
  input wire logic rx_read_in,
  output logic [8:0] rx_data_out,
  output logic transmit_ready_flag_out,
  output logic transmit_empty_flag_out,
  output logic receive_ready_flag_out,
  output logic overrun_flag_out,
  output logic underrun_flag_out,
  output logic rx_timeout_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic select_in,
  output logic select_out
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic sck_prev;
  logic sck_s;
  logic sdi_s;
  logic sel_s;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      sck_prev <= 1'b1;
    end else begin
      pin_meta <= {sck_in, serial_in, select_in};
      pin_sync <= pin_meta;
      sck_prev <= pin_sync[2];
    end
  end

  assign sck_s = pin_sync[2];
  assign sdi_s = pin_sync[1];
  assign sel_s = pin_sync[0];

  // ----------------------------------------------------------------------
  // Mode decode and character length
  // ----------------------------------------------------------------------
  logic is_master;
  logic is_slave;
  localparam int CNT_W = usart_spi_pkg::CNT_W;
  logic [3:0] n_bits;
  logic [CNT_W-1:0] last_edge;


  assign is_master = (mode_in == usart_spi_pkg::MODE_SPI_MASTER);
  assign is_slave = (mode_in == usart_spi_pkg::MODE_SPI_SLAVE);
  assign n_bits = nine_bit_in ? usart_spi_pkg::CHAR_NINE_LEN :
    usart_spi_pkg::CHAR_BASE_LEN + {2'h0, char_length_field_in};
  assign last_edge = CNT_W'({n_bits, 1'b0}) - 1'b1;

  // Receive timeout cannot arise: bit clock only runs inside transfers
  assign rx_timeout_out = 1'b0;

  // ----------------------------------------------------------------------
  // Transmit holding buffer
  // ----------------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_empty;
  logic [8:0] fifo_data;
  logic tx_accept;

  assign transmit_ready_flag_out = tx_enable_in && fifo_in_ready;
  assign tx_accept = tx_write_in && transmit_ready_flag_out;

  spi_fifo #(
    .WIDTH(usart_spi_pkg::DATA_W),
    .DEPTH(usart_spi_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .flush_in(tx_reset_in),
    .in_valid_in(tx_accept),
    .in_ready_out(fifo_in_ready),
    .in_data_in(tx_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data),
    .empty_out(fifo_empty)
  );

  // ----------------------------------------------------------------------
  // Master baud timing
  // ----------------------------------------------------------------------
  usart_spi_pkg::master_state_e state;
  logic [15:0] baud_cnt;
  logic [15:0] half_div;
  logic half_tick;
  logic bit_tick;
  logic [CNT_W-1:0] edge_cnt;
  logic [CNT_W-1:0] gap_cnt;
  logic sck_int;
  logic m_start;

  assign half_div = baud_divider_in >> 1;
  assign half_tick = (baud_cnt == half_div - usart_spi_pkg::DIV_ONE);
  assign bit_tick = (baud_cnt == baud_divider_in - usart_spi_pkg::DIV_ONE);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      baud_cnt <= '0;
    end else if (state == usart_spi_pkg::ST_IDLE || bit_tick) begin
      baud_cnt <= '0;
    end else begin
      baud_cnt <= baud_cnt + 1'b1;
    end
  end

  // Pending character may go only if wait-read is satisfied
  assign m_start = is_master && tx_enable_in && fifo_valid &&
    !(wait_read_before_send_in && receive_ready_flag_out);

  // ----------------------------------------------------------------------
  // Master character sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= usart_spi_pkg::ST_IDLE;
      edge_cnt <= '0;
      gap_cnt <= '0;
      sck_int <= 1'b0;
    end else if (tx_reset_in || !is_master) begin
      state <= usart_spi_pkg::ST_IDLE;
      edge_cnt <= '0;
      gap_cnt <= '0;
      sck_int <= 1'b0;
    end else begin
      case (state)
        usart_spi_pkg::ST_IDLE: begin
          sck_int <= 1'b0;
          edge_cnt <= '0;
          if (m_start) begin
            state <= usart_spi_pkg::ST_LEAD;
          end
        end
        usart_spi_pkg::ST_LEAD: begin
          if (bit_tick) begin
            state <= usart_spi_pkg::ST_SHIFT;
          end
        end
        usart_spi_pkg::ST_SHIFT: begin
          if (half_tick || bit_tick) begin
            sck_int <= !sck_int;
            edge_cnt <= edge_cnt + 1'b1;
            if (edge_cnt == last_edge) begin
              state <= usart_spi_pkg::ST_TRAIL;
            end
          end
        end
        usart_spi_pkg::ST_TRAIL: begin
          if (bit_tick) begin
            state <= usart_spi_pkg::ST_GAP;
            gap_cnt <= '0;
          end
        end
        usart_spi_pkg::ST_GAP: begin
          if (bit_tick) begin
            gap_cnt <= gap_cnt + 1'b1;
            if (gap_cnt == usart_spi_pkg::GAP_BITS - 1'b1) begin
              state <= usart_spi_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= usart_spi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Select line and serial clock outputs
  // ----------------------------------------------------------------------
  logic select_forced;
  logic m_selected;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      select_forced <= 1'b0;
    end else if (select_force_bit_in) begin
      select_forced <= 1'b1;
    end else if (select_release_bit_in) begin
      select_forced <= 1'b0;
    end
  end

  assign m_selected = (state == usart_spi_pkg::ST_LEAD) ||
    (state == usart_spi_pkg::ST_SHIFT) || (state == usart_spi_pkg::ST_TRAIL);
  assign select_out = !(is_master && (m_selected || select_forced));
  // Idle toggle state is zero, so the pin rests at the polarity level
  assign sck_out = sck_int ^ cpol_in;
  assign sck_oe_out = is_master && clock_output_enable_in;

  // ----------------------------------------------------------------------
  // Clock edge sources
  // ----------------------------------------------------------------------
  logic lead_edge;
  logic trail_edge;
  logic s_lead;
  logic s_trail;
  logic m_lead;
  logic m_trail;
  logic sample_edge;
  logic shift_edge;

  // Slave ignores the baud setting and uses the pin clock
  assign s_lead = is_slave && !sel_s && (sck_s != sck_prev) &&
    (sck_prev == cpol_in);
  assign s_trail = is_slave && !sel_s && (sck_s != sck_prev) &&
    (sck_prev != cpol_in);
  assign m_lead = (state == usart_spi_pkg::ST_SHIFT) &&
    (half_tick || bit_tick) && !sck_int;
  assign m_trail = (state == usart_spi_pkg::ST_SHIFT) &&
    (half_tick || bit_tick) && sck_int;
  assign lead_edge = m_lead || s_lead;
  assign trail_edge = m_trail || s_trail;
  // Phase 1 samples on the leading edge, phase 0 on the trailing one
  assign sample_edge = cpha_in ? lead_edge : trail_edge;
  assign shift_edge = cpha_in ? trail_edge : lead_edge;

  // ----------------------------------------------------------------------
  // Shift core shared by both roles
  // ----------------------------------------------------------------------
  logic [8:0] tx_shift;
  logic [8:0] rx_shift;
  logic [3:0] bit_cnt;
  logic s_busy;
  logic s_start;
  logic char_done;
  logic [8:0] load_word;

  assign s_start = is_slave && !sel_s && !s_busy;
  // Left-justify so bit 8 always carries the MSB
  assign load_word = fifo_data <<
    (usart_spi_pkg::CHAR_NINE_LEN - n_bits);
  assign fifo_pop = ((state == usart_spi_pkg::ST_IDLE) && m_start) ||
    (s_start && tx_enable_in && fifo_valid);
  assign char_done = sample_edge && (bit_cnt == n_bits - 1'b1);
  assign serial_out = tx_shift[8];

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_busy <= 1'b0;
    end else if (!is_slave || sel_s || rx_reset_in) begin
      s_busy <= 1'b0;
    end else if (s_start) begin
      s_busy <= 1'b1;
    end else if (char_done) begin
      s_busy <= 1'b0;
    end
  end

  // No start, parity or stop bits are framed around the data
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_shift <= usart_spi_pkg::DATA_ONES;
    end else if (tx_reset_in) begin
      tx_shift <= usart_spi_pkg::DATA_ONES;
    end else if (fifo_pop) begin
      tx_shift <= load_word;
    end else if (s_start) begin
      tx_shift <= usart_spi_pkg::DATA_ONES;
    end else if (shift_edge && bit_cnt != 4'h0) begin
      tx_shift <= {tx_shift[7:0], 1'b1};
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_shift <= usart_spi_pkg::DATA_ZERO;
      bit_cnt <= 4'h0;
    end else if (s_start || (is_slave ? sel_s :
                 (state == usart_spi_pkg::ST_IDLE))) begin
      rx_shift <= usart_spi_pkg::DATA_ZERO;
      bit_cnt <= 4'h0;
    end else if (char_done) begin
      bit_cnt <= 4'h0;
    end else if (sample_edge) begin
      rx_shift <= {rx_shift[7:0], sdi_s};
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit status
  // ----------------------------------------------------------------------
  logic tx_active;

  assign tx_active = (is_master && (state != usart_spi_pkg::ST_IDLE)) ||
    s_busy;
  assign transmit_empty_flag_out = tx_enable_in && fifo_empty &&
    !tx_active;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      underrun_flag_out <= 1'b0;
    end else if (s_start && !(tx_enable_in && fifo_valid)) begin
      underrun_flag_out <= 1'b1;
    end else if (status_reset_bit_in || tx_reset_in) begin
      underrun_flag_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Receive holding register
  // ----------------------------------------------------------------------
  logic rx_load;

  assign rx_load = char_done && rx_enable_in;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_data_out <= usart_spi_pkg::DATA_ZERO;
    end else if (rx_load) begin
      rx_data_out <= {rx_shift[7:0], sdi_s};
    end
  end

  // A completion in the read cycle still wins
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      receive_ready_flag_out <= 1'b0;
    end else if (rx_load) begin
      receive_ready_flag_out <= 1'b1;
    end else if (rx_read_in || rx_reset_in) begin
      receive_ready_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overrun_flag_out <= 1'b0;
    end else if (rx_load && receive_ready_flag_out && !rx_read_in) begin
      overrun_flag_out <= 1'b1;
    end else if (status_reset_bit_in || rx_reset_in) begin
      overrun_flag_out <= 1'b0;
    end
  end

endmodule // usart_spi

// *** usart_spi_pkg.sv ***
// Constants and types shared by the SPI-mode serial controller files
package usart_spi_pkg;

  // ----------------------------------------------------------------------
  // Operating mode codes and widths
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_SPI_MASTER = 4'hE;
  localparam logic [3:0] MODE_SPI_SLAVE = 4'hF;
  localparam int DATA_W = 9;
  localparam int DIV_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;

  // ----------------------------------------------------------------------
  // Character and framing figures
  // ----------------------------------------------------------------------
  localparam logic [3:0] CHAR_BASE_LEN = 4'h5;
  localparam logic [3:0] CHAR_NINE_LEN = 4'h9;
  localparam logic [CNT_W-1:0] GAP_BITS = 5'h03;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_ONES = 9'h1FF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;

  // ----------------------------------------------------------------------
  // Master character sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LEAD  = 5'h02,
    ST_SHIFT = 5'h04,
    ST_TRAIL = 5'h08,
    ST_GAP   = 5'h10
  } master_state_e;

endpackage

// *** spi_fifo.sv ***
// Small first-in first-out buffer with registered read data
`timescale 1ns/1ps
module spi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic empty_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW-1:0] next_rd_ptr;

  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign empty_out = (count == '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head word kept in a register; bypass covers a write to the head slot
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_data_out <= '0;
    end else if (push && (wr_ptr == next_rd_ptr)) begin
      out_data_out <= in_data_in;
    end else begin
      out_data_out <= mem[next_rd_ptr];
    end
  end

endmodule // spi_fifo

// *** usart_spi_checker.sv ***
// Port-level assertions for the SPI-mode serial controller
`timescale 1ns/1ps
module usart_spi_checker (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] mode_in,
  input wire logic clock_output_enable_in,
  input wire logic [15:0] baud_divider_in,
  input wire logic cpol_in,
  input wire logic tx_enable_in,
  input wire logic tx_reset_in,
  input wire logic rx_reset_in,
  input wire logic select_force_bit_in,
  input wire logic select_release_bit_in,
  input wire logic status_reset_bit_in,
  input wire logic transmit_ready_flag_out,
  input wire logic transmit_empty_flag_out,
  input wire logic receive_ready_flag_out,
  input wire logic overrun_flag_out,
  input wire logic underrun_flag_out,
  input wire logic rx_timeout_out,
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic select_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ---------------------------------------------------------------
  // Helpers: forced select and length of the select-high gap
  // ---------------------------------------------------------------
  logic master;
  logic forced;
  logic [19:0] high_cnt;
  assign master = mode_in == usart_spi_pkg::MODE_SPI_MASTER;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) forced <= 1'b0;
    else if (select_force_bit_in) forced <= 1'b1;
    else if (select_release_bit_in) forced <= 1'b0;
  end
  // Saturated outside master so a first character is never judged
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) high_cnt <= 20'hFFFFE;
    else if (!master) high_cnt <= 20'hFFFFE;
    else if (!select_out) high_cnt <= 20'h00000;
    else if (high_cnt != 20'hFFFFE) high_cnt <= high_cnt + 20'h00001;
  end
  sequence idle_line;
    master && select_out;
  endsequence
  sequence char_start;
    master && !forced && $fell(select_out);
  endsequence
  timeout_never_a:
    assert property (rx_timeout_out == 1'b0)
    else $error("receiver timeout flag raised");
  flags_disabled_a:
    assert property (!tx_enable_in |-> !transmit_ready_flag_out &&
      !transmit_empty_flag_out)
    else $error("transmit flags high while disabled");
  clock_pin_a:
    assert property (mode_in[3:1] == 3'h7 |->
      sck_oe_out == (master && clock_output_enable_in))
    else $error("clock pin enable wrong for mode");
  clock_rest_a:
    assert property (idle_line |-> sck_out == cpol_in)
    else $error("serial clock not at rest level");
  select_forced_a:
    assert property (master && forced |-> !select_out)
    else $error("select high while forced");
  select_gap_a:
    assert property (char_start |->
      high_cnt + 20'h00001 >= 20'(baud_divider_in) * 20'h00003)
    else $error("select gap shorter than three bits");
  overrun_cause_a:
    assert property ($rose(overrun_flag_out) |->
      $past(receive_ready_flag_out))
    else $error("overrun without pending character");
  underrun_mode_a:
    assert property ($rose(underrun_flag_out) |->
      mode_in == usart_spi_pkg::MODE_SPI_SLAVE)
    else $error("underrun outside slave mode");
  status_clear_a:
    assert property ($fell(overrun_flag_out) || $fell(underrun_flag_out)
      |-> $past(status_reset_bit_in || tx_reset_in || rx_reset_in))
    else $error("error flag cleared without request");
endmodule // usart_spi_checker

bind usart_spi usart_spi_checker u_chk (.*);

// *** spi_peer_model.sv ***
// Far-side SPI peer: slave answering the controller, or master driving it
`timescale 1ns/1ps
module spi_peer_model (
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic sck_in,
  input wire logic select_in,
  input wire logic data_in,
  output logic data_out,
  output logic sck_out,
  output logic select_out
);
  // ---------------------------------------------------------------
  // Shift state, outgoing characters left-justified at bit 8, received ones right-justified
  // ---------------------------------------------------------------
  logic [8:0] reply = 9'h000;
  logic [8:0] shift = 9'h000;
  logic [8:0] got = 9'h000;
  logic sampled = 1'b0;
  int n_got = 0;
  initial begin
    data_out = 1'b1;
    sck_out = 1'b0;
    select_out = 1'b1;
  end
  always @(negedge select_in) begin
    shift = reply;
    data_out = reply[8];
    sampled = 1'b0;
  end
  // Released line has no pull, so show the inverse of the last bit
  always @(posedge select_in) begin
    n_got++;
    data_out = ~data_out;
  end
  always @(sck_in) begin
    if (!select_in && (sck_in != cpol_in) == cpha_in) begin
      got = {got[7:0], data_in};
      sampled = 1'b1;
    end else if (!select_in && sampled) begin
      shift = shift << 1;
      data_out = shift[8];
    end
  end
  task automatic send(input logic [8:0] word, input int bits);
    #13;
    sck_out = cpol_in;
    select_out = 1'b0;
    data_out = word[8];
    #800;
    for (int i = 0; i < 2 * bits; i++) begin
      sck_out = ~sck_out;
      if ((sck_out != cpol_in) == cpha_in) got = {got[7:0], data_in};
      else if (i > 0) begin
        word = word << 1;
        data_out = word[8];
      end
      #400;
    end
    #400;
    select_out = 1'b1;
    data_out = ~data_out;
    #800;
  endtask
endmodule // spi_peer_model

// *** usart_spi_bench.sv ***
// Self-checking bench for the SPI-mode serial controller
`timescale 1ns/1ps
module usart_spi_bench;
  // ---------------------------------------------------------------
  // Design pins and far-side peer
  // ---------------------------------------------------------------
  logic core_clk_in, reset_n_in, clock_output_enable_in, nine_bit_in;
  logic cpol_in, cpha_in, wait_read_before_send_in, tx_enable_in;
  logic rx_enable_in, tx_reset_in, rx_reset_in, select_force_bit_in;
  logic select_release_bit_in, status_reset_bit_in, tx_write_in;
  logic rx_read_in, transmit_ready_flag_out, transmit_empty_flag_out;
  logic receive_ready_flag_out, overrun_flag_out, underrun_flag_out;
  logic rx_timeout_out, sck_in, sck_out, sck_oe_out, serial_in;
  logic serial_out, select_in, select_out;
  logic [3:0] mode_in;
  logic [15:0] baud_divider_in;
  logic [1:0] char_length_field_in;
  logic [8:0] tx_data_in, rx_data_out;
  int n_fail = 0;
  int n_tests = 0;
  usart_spi u_dut (.*);
  spi_peer_model u_peer (
    .cpol_in(cpol_in),
    .cpha_in(cpha_in),
    .sck_in(sck_out),
    .select_in(select_out),
    .data_in(serial_out),
    .data_out(serial_in),
    .sck_out(sck_in),
    .select_out(select_in)
  );
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk_in);
    s = 1'b0;
    @(negedge core_clk_in);
  endtask
  task automatic wait_for(ref logic s, input logic lvl);
    for (int i = 0; i < 4000 && s !== lvl; i++) @(negedge core_clk_in);
    check("wait", s, lvl);
    if (s !== lvl) print_verdict();
  endtask
  task automatic put(input logic [8:0] d);
    tx_data_in = d;
    pulse(tx_write_in);
  endtask
  task automatic xfer(input logic [8:0] d, r, input int n);
    u_peer.reply = 9'(r << (9 - n));
    put(d);
    wait_for(receive_ready_flag_out, 1'b1);
    check("peer_rx", u_peer.got & 9'((1 << n) - 1), d);
    check("rx_data", rx_data_out, r);
    pulse(rx_read_in);
    // Format may only change once the line is idle again
    wait_for(transmit_empty_flag_out, 1'b1);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset();
    check("rdy_off", transmit_ready_flag_out, 1'b0);
    check("empty_off", transmit_empty_flag_out, 1'b0);
    check("sel_idle", select_out, 1'b1);
    check("rx_rst", rx_data_out, 9'h000);
    tx_enable_in = 1'b1;
    @(negedge core_clk_in);
    check("rdy_on", transmit_ready_flag_out, 1'b1);
    check("empty_on", transmit_empty_flag_out, 1'b1);
  endtask
  task automatic sc_formats();
    int n;
    for (int i = 0; i < 5; i++) begin
      cpol_in = i[1];
      cpha_in = ~i[0];
      nine_bit_in = i[2];
      char_length_field_in = i[1:0];
      n = i < 4 ? 5 + i : 9;
      xfer(9'h1A5 & 9'((1 << n) - 1), 9'h0CB & 9'((1 << n) - 1), n);
    end
    {cpol_in, cpha_in, nine_bit_in} = 3'h2;
    char_length_field_in = 2'h3;
  endtask
  task automatic sc_wait_read();
    wait_read_before_send_in = 1'b1;
    put(9'h03C);
    wait_for(receive_ready_flag_out, 1'b1);
    put(9'h0E7);
    repeat (300) @(negedge core_clk_in);
    check("held", u_peer.got & 9'h0FF, 9'h03C);
    pulse(rx_read_in);
    wait_for(receive_ready_flag_out, 1'b1);
    check("sent", u_peer.got & 9'h0FF, 9'h0E7);
    pulse(rx_read_in);
    wait_read_before_send_in = 1'b0;
  endtask
  task automatic sc_burst();
    u_peer.reply = 9'h1E0;
    tx_data_in = 9'h011;
    tx_write_in = 1'b1;
    @(negedge core_clk_in);
    tx_data_in = 9'h022;
    @(negedge core_clk_in);
    tx_write_in = 1'b0;
    check("busy", transmit_empty_flag_out, 1'b0);
    wait_for(transmit_empty_flag_out, 1'b1);
    check("second", u_peer.got & 9'h0FF, 9'h022);
    check("overrun", overrun_flag_out, 1'b1);
    check("kept", rx_data_out, 9'h0F0);
    pulse(status_reset_bit_in);
    check("ovr_clr", overrun_flag_out, 1'b0);
    pulse(rx_read_in);
  endtask
  task automatic sc_force();
    u_peer.reply = 9'h14A;
    pulse(select_force_bit_in);
    check("forced", select_out, 1'b0);
    put(9'h05A);
    wait_for(transmit_empty_flag_out, 1'b1);
    check("f_tx", u_peer.got & 9'h0FF, 9'h05A);
    check("f_rx", rx_data_out, 9'h0A5);
    check("held_low", select_out, 1'b0);
    pulse(rx_read_in);
    pulse(select_release_bit_in);
    check("released", select_out, 1'b1);
  endtask
  task automatic sc_fill();
    int base;
    mode_in = 4'h0;
    pulse(tx_reset_in);
    for (int i = 0; i < 17; i++) put(9'(i));
    check("full", transmit_ready_flag_out, 1'b0);
    base = u_peer.n_got;
    mode_in = usart_spi_pkg::MODE_SPI_MASTER;
    wait_for(transmit_empty_flag_out, 1'b1);
    check("drained", 9'(u_peer.n_got - base), 9'h010);
    check("last", u_peer.got & 9'h0FF, 9'h00F);
    pulse(status_reset_bit_in);
    pulse(rx_read_in);
  endtask
  task automatic sc_slave();
    mode_in = usart_spi_pkg::MODE_SPI_SLAVE;
    baud_divider_in = 16'h0003;
    pulse(tx_reset_in);
    pulse(rx_reset_in);
    put(9'h05A);
    u_peer.send(9'h12C, 8);
    @(negedge core_clk_in);
    check("miso", u_peer.got & 9'h0FF, 9'h05A);
    wait_for(receive_ready_flag_out, 1'b1);
    check("mosi", rx_data_out, 9'h096);
    pulse(rx_read_in);
    pulse(status_reset_bit_in);
    u_peer.send(9'h000, 8);
    @(negedge core_clk_in);
    check("ones", u_peer.got & 9'h0FF, 9'h0FF);
    check("underrun", underrun_flag_out, 1'b1);
    pulse(status_reset_bit_in);
    check("unr_clr", underrun_flag_out, 1'b0);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  initial begin
    {reset_n_in, nine_bit_in, cpol_in, wait_read_before_send_in} = 4'h0;
    {tx_enable_in, tx_reset_in, rx_reset_in, select_force_bit_in} = 4'h0;
    {select_release_bit_in, status_reset_bit_in, tx_write_in} = 3'h0;
    rx_read_in = 1'b0;
    {clock_output_enable_in, rx_enable_in, cpha_in} = 3'h7;
    mode_in = usart_spi_pkg::MODE_SPI_MASTER;
    baud_divider_in = 16'h0008;
    char_length_field_in = 2'h3;
    tx_data_in = 9'h000;
    repeat (16) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    sc_reset();
    sc_formats();
    sc_wait_read();
    sc_burst();
    sc_force();
    sc_fill();
    sc_slave();
    print_verdict();
  end
endmodule // usart_spi_bench
